//--- logic/cmfc_defs.svh
// Purpose: Offsets, field positions, reset values and codes for the cache mode and flush control.
// Assumes: AXI4-Lite slave with 32-bit data, one aligned word per register.
// Notes: Definitions only.
`ifndef CMFC_DEFS_SVH
`define CMFC_DEFS_SVH
`define CMFC_OFF_WB 12'h000
`define CMFC_OFF_WBINV 12'h004
`define CMFC_OFF_CFG 12'h008
`define CMFC_OFF_PCS 12'h00c
`define CMFC_OFF_LINES 12'h010
`define CMFC_OFF_RANGE 12'h400
`define CMFC_TRIG_BIT 0
`define CMFC_CE_BIT 0
`define CMFC_DCC_LSB 2
`define CMFC_PCC_LSB 5
`define CMFC_SPLIT_RST 3'h0
`define CMFC_MODE_CACHE0 3'h0
`define CMFC_MODE_CACHE1 3'h2
`define CMFC_RANGE_SHIFT 24
`define CMFC_RESP_OKAY 2'h0
`define CMFC_RESP_SLVERR 2'h2
`define CMFC_L2_READ_TOP 32'h0010_0fff
`endif

//--- logic/cmfc_pkg.sv
// Purpose: Types shared by the cache mode and flush control.
// Assumes: Used together with cmfc_defs.svh.
// Notes: Payloads of the bus carried as packed structs.
package cmfc_pkg;
  // Write request as taken from the bus
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } cmfc_wreq_t;
  // Cache mode fields driven towards the cores and caches
  typedef struct packed {
    logic [2:0] split;
    logic [2:0] dcc;
    logic [2:0] program_cache_control;
  } cmfc_mode_t;
  // Sweep machine states
  typedef enum logic [1:0] {CMFC_IDLE, CMFC_SWEEP, CMFC_DONE} cmfc_sweep_t;
endpackage : cmfc_pkg

//--- logic/cmfc_sweep.sv
// Purpose: Walks every second-level line once for a global writeback or writeback-invalidate.
// Assumes: The line engine answers each request with line_done.
// Notes: One sweep at a time; the start pulse is ignored while busy.
`include "cmfc_defs.svh"
module cmfc_sweep
  import cmfc_pkg::*;
#(
  parameter int LINES = 2048
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic inval,
  output logic busy,
  output logic line_req,
  output logic line_inval,
  output logic [15:0] line_idx,
  input wire logic line_done,
  output logic finish
);
  initial begin
    if (LINES < 1 || LINES > 65536) $error("cmfc_sweep: LINES out of range");
  end

  cmfc_sweep_t st_r, st_nxt; // Sweep state
  logic [15:0] idx_r, idx_nxt; // Line under work
  logic inv_r, inv_nxt; // Invalidate after writeback

  // Next state: step one line per engine answer
  always_comb begin
    st_nxt = st_r;
    idx_nxt = idx_r;
    inv_nxt = inv_r;
    unique case (st_r)
      CMFC_IDLE: begin
        if (start) begin
          st_nxt = CMFC_SWEEP;
          idx_nxt = 16'h0000;
          inv_nxt = inval;
        end
      end
      CMFC_SWEEP: begin
        if (line_done) begin
          // Last line written back: the sweep is over
          if (idx_r == 16'(LINES - 1)) st_nxt = CMFC_DONE;
          else idx_nxt = idx_r + 16'h0001;
        end
      end
      CMFC_DONE: st_nxt = CMFC_IDLE;
      default: st_nxt = CMFC_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= CMFC_IDLE;
      idx_r <= 16'h0000;
      inv_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      idx_r <= idx_nxt;
      inv_r <= inv_nxt;
    end
  end

  assign busy = (st_r != CMFC_IDLE);
  assign line_req = (st_r == CMFC_SWEEP);
  assign line_inval = inv_r;
  assign line_idx = idx_r;
  assign finish = (st_r == CMFC_DONE);
endmodule : cmfc_sweep

//--- logic/cmfc_top.sv
// Purpose: Cache mode selection, range cacheability and global flush triggers behind an AXI4-Lite slave.
// Assumes: MCLK 250 MHz, RSTN asynchronous active low; a line engine serves sweep requests.
// Notes: Registers at byte offsets from the defs header; range registers at RANGE + 4*n.
//
// Overview of operation
// [R1] Writeback trigger writes back every second-level line
// [R2] Invalidate trigger writes back then invalidates all
// [R3] Upper bits of trigger/range registers read zero
// [R4] Each range register covers one 16-Mbyte block
// [R5] Range enable set permits caching, reset forbids
// [R6] Data cache is cache only, no bypass
// [R7] Data control accepts 000/010, both two-way
// [R8] Program cache is cache only, no bypass
// [R9] Program control accepts 000/010, direct mapped
// [R10] Split resets to 000, all SRAM
// [R11] All-SRAM forwards external requests, keeps no copy
// [R12] Cache takes the top SRAM addresses first
// [R13] Reads up to 0010 0FFFh never disturb cache
// [R14] Software never writes cache-configured addresses
// [R15] Range cacheability independent of split mode
// [R16] Software evacuates SRAM before converting to cache
// [R17] Software flushes external ranges leaving all-SRAM
// [R18] Software global-invalidates before giving up cache
// [R19] Software reads configuration back, then 8 idles
// [R20] Invalidate trigger reads 1 until complete
// [R21] Writeback trigger reads 1 until complete
`include "cmfc_defs.svh"
module cmfc_top
  import cmfc_pkg::*;
#(
  parameter int NRANGE = 256,
  parameter int LINES = 2048
) (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [31:0] REQ_ADDR,
  input wire logic REQ_EXT,
  input wire logic REQ_WRITE,
  output logic REQ_CACHEABLE,
  output logic REQ_L2_ALLOC,
  output logic REQ_L2_READ_SAFE,
  output logic [2:0] SECOND_LEVEL_SPLIT,
  output logic [2:0] DATA_CACHE_CONTROL,
  output logic [2:0] PROGRAM_CACHE_CONTROL,
  output logic LINE_REQ,
  output logic LINE_INVAL,
  output logic [15:0] LINE_IDX,
  input wire logic LINE_DONE
);
  initial begin
    if (NRANGE < 1 || NRANGE > 256) $error("cmfc_top: NRANGE must be 1..256");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write channel capture
  ////////////////////////////////////////////////////////////////////////////
  logic aw_have_r, aw_have_nxt; // Address held
  logic w_have_r, w_have_nxt; // Data held
  logic b_valid_r, b_valid_nxt; // Response pending
  logic [1:0] b_resp_r, b_resp_nxt; // Response code
  cmfc_wreq_t wq_r, wq_nxt; // Captured request
  logic wr_fire; // Both halves present, commit now
  logic wr_ok; // Address maps to a register
  logic [7:0] wr_ridx; // Range register index

  assign S_AXI_AWREADY = !aw_have_r && !b_valid_r;
  assign S_AXI_WREADY = !w_have_r && !b_valid_r;
  assign wr_fire = aw_have_r && w_have_r && !b_valid_r;
  assign S_AXI_BVALID = b_valid_r;
  assign S_AXI_BRESP = b_resp_r;
  assign wr_ridx = wq_r.addr[9:2];

  // Decode of the held write address
  always_comb begin
    wr_ok = 1'b0;
    if (wq_r.addr[11:10] == `CMFC_OFF_RANGE >> 10) wr_ok = (int'(wr_ridx) < NRANGE);
    else if (wq_r.addr == `CMFC_OFF_WB || wq_r.addr == `CMFC_OFF_WBINV ||
             wq_r.addr == `CMFC_OFF_CFG || wq_r.addr == `CMFC_OFF_PCS) wr_ok = 1'b1;
  end

  // Address and data may arrive in either order; response follows both
  always_comb begin
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    b_valid_nxt = b_valid_r;
    b_resp_nxt = b_resp_r;
    wq_nxt = wq_r;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_have_nxt = 1'b1;
      wq_nxt.addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_have_nxt = 1'b1;
      wq_nxt.data = S_AXI_WDATA;
      wq_nxt.strb = S_AXI_WSTRB;
    end
    if (wr_fire) begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      b_valid_nxt = 1'b1;
      b_resp_nxt = wr_ok ? `CMFC_RESP_OKAY : `CMFC_RESP_SLVERR;
    end else if (b_valid_r && S_AXI_BREADY) begin
      b_valid_nxt = 1'b0;
    end
  end

  // Write channel registers
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      b_valid_r <= 1'b0;
      b_resp_r <= 2'h0;
      wq_r <= '0;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      b_valid_r <= b_valid_nxt;
      b_resp_r <= b_resp_nxt;
      wq_r <= wq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control state: triggers, modes, range enables
  ////////////////////////////////////////////////////////////////////////////
  logic wb_r, wb_nxt; // Writeback trigger, held while sweeping
  logic wbinv_r, wbinv_nxt; // Writeback-invalidate trigger
  cmfc_mode_t mode_r, mode_nxt; // Split and L1 control fields
  logic [NRANGE-1:0] ce_r, ce_nxt; // One enable per 16-Mbyte block
  logic sw_busy; // Sweep engine working
  logic sw_finish; // Sweep engine finished pulse
  logic sw_start; // Launch a sweep
  logic wr_lo; // Low byte lane written
  logic [2:0] wr_code_d; // Candidate data control code
  logic [2:0] wr_code_p; // Candidate program control code

  assign wr_lo = wr_fire && wr_ok && wq_r.strb[0];
  assign wr_code_d = wq_r.data[`CMFC_DCC_LSB +: 3];
  assign wr_code_p = wq_r.data[`CMFC_PCC_LSB +: 3];

  // A trigger is launched by writing 1 while no sweep runs; a write of 0
  // cannot abort a sweep, since partial flushes would lose dirty data.
  always_comb begin
    wb_nxt = wb_r;
    wbinv_nxt = wbinv_r;
    mode_nxt = mode_r;
    ce_nxt = ce_r;
    sw_start = 1'b0;
    if (sw_finish) begin
      wb_nxt = 1'b0; // R21
      wbinv_nxt = 1'b0; // R20
    end
    if (wr_lo && !sw_busy && !wb_r && !wbinv_r) begin
      if (wq_r.addr == `CMFC_OFF_WB && wq_r.data[`CMFC_TRIG_BIT]) begin
        wb_nxt = 1'b1; // R1
        sw_start = 1'b1;
      end
      if (wq_r.addr == `CMFC_OFF_WBINV && wq_r.data[`CMFC_TRIG_BIT]) begin
        wbinv_nxt = 1'b1; // R2
        sw_start = 1'b1;
      end
    end
    if (wr_lo && wq_r.addr == `CMFC_OFF_CFG) mode_nxt.split = wq_r.data[2:0];
    if (wr_lo && wq_r.addr == `CMFC_OFF_PCS) begin
      // Reserved codes are refused and the old mode kept
      if (wr_code_d == `CMFC_MODE_CACHE0 || wr_code_d == `CMFC_MODE_CACHE1) mode_nxt.dcc = wr_code_d; // R7
      if (wr_code_p == `CMFC_MODE_CACHE0 || wr_code_p == `CMFC_MODE_CACHE1) mode_nxt.program_cache_control = wr_code_p; // R9
    end
    if (wr_lo && wq_r.addr[11:10] == `CMFC_OFF_RANGE >> 10) ce_nxt[wr_ridx] = wq_r.data[`CMFC_CE_BIT]; // R5
  end

  // Control registers
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      wb_r <= 1'b0;
      wbinv_r <= 1'b0;
      mode_r <= '{split: `CMFC_SPLIT_RST, dcc: 3'h0, program_cache_control: 3'h0}; // R10
      ce_r <= '0;
    end else begin
      wb_r <= wb_nxt;
      wbinv_r <= wbinv_nxt;
      mode_r <= mode_nxt;
      ce_r <= ce_nxt;
    end
  end

  // Global sweep over every second-level line
  cmfc_sweep #(.LINES(LINES)) u_sweep (
    .clk(MCLK),
    .rst_n(RSTN),
    .start(sw_start),
    .inval(wbinv_nxt),
    .busy(sw_busy),
    .line_req(LINE_REQ),
    .line_inval(LINE_INVAL),
    .line_idx(LINE_IDX),
    .line_done(LINE_DONE),
    .finish(sw_finish)
  );

  // The L1 caches have no freeze/bypass, so the fields only carry the two-way
  // and direct-mapped cache codes
  assign DATA_CACHE_CONTROL = mode_r.dcc; // R6
  assign PROGRAM_CACHE_CONTROL = mode_r.program_cache_control; // R8
  assign SECOND_LEVEL_SPLIT = mode_r.split; // R12

  ////////////////////////////////////////////////////////////////////////////
  // Request attributes
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] req_blk; // 16-Mbyte block of the request

  assign req_blk = REQ_ADDR[31:`CMFC_RANGE_SHIFT];

  // Cacheability looks only at REQ_EXT and the range enable, never at the split
  always_comb begin
    REQ_CACHEABLE = 1'b0;
    if (REQ_EXT && int'(req_blk) < NRANGE) REQ_CACHEABLE = ce_r[req_blk]; // R4 R15
  end
  // In all-SRAM mode requests still go out but the second level keeps no copy
  assign REQ_L2_ALLOC = REQ_CACHEABLE && (mode_r.split != `CMFC_SPLIT_RST); // R11
  // Reads anywhere in the allotted window are safe even where cache lives
  assign REQ_L2_READ_SAFE = !REQ_EXT && !REQ_WRITE && (REQ_ADDR <= `CMFC_L2_READ_TOP); // R13

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  ////////////////////////////////////////////////////////////////////////////
  logic r_valid_r, r_valid_nxt; // Read data pending
  logic [31:0] r_data_r, r_data_nxt; // Read data
  logic [1:0] r_resp_r, r_resp_nxt; // Read response
  logic [7:0] rd_ridx; // Range index of read

  assign S_AXI_ARREADY = !r_valid_r;
  assign S_AXI_RVALID = r_valid_r;
  assign S_AXI_RDATA = r_data_r;
  assign S_AXI_RRESP = r_resp_r;
  assign rd_ridx = S_AXI_ARADDR[9:2];

  // Decode and capture; upper bits of trigger and range words read zero
  always_comb begin
    r_valid_nxt = r_valid_r;
    r_data_nxt = r_data_r;
    r_resp_nxt = r_resp_r;
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      r_valid_nxt = 1'b1;
      r_data_nxt = 32'h0000_0000; // R3
      r_resp_nxt = `CMFC_RESP_OKAY;
      if (S_AXI_ARADDR[11:10] == `CMFC_OFF_RANGE >> 10) begin
        if (int'(rd_ridx) < NRANGE) r_data_nxt[`CMFC_CE_BIT] = ce_r[rd_ridx];
        else r_resp_nxt = `CMFC_RESP_SLVERR;
      end else begin
        unique case (S_AXI_ARADDR)
          `CMFC_OFF_WB: r_data_nxt[`CMFC_TRIG_BIT] = wb_r; // R21
          `CMFC_OFF_WBINV: r_data_nxt[`CMFC_TRIG_BIT] = wbinv_r; // R20
          `CMFC_OFF_CFG: r_data_nxt[2:0] = mode_r.split;
          `CMFC_OFF_PCS: r_data_nxt = {24'h0, mode_r.program_cache_control, mode_r.dcc, 2'h0};
          `CMFC_OFF_LINES: r_data_nxt = 32'(LINES);
          default: r_resp_nxt = `CMFC_RESP_SLVERR;
        endcase
      end
    end else if (r_valid_r && S_AXI_RREADY) begin
      r_valid_nxt = 1'b0;
    end
  end

  // Read channel registers
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      r_valid_r <= 1'b0;
      r_data_r <= 32'h0000_0000;
      r_resp_r <= 2'h0;
    end else begin
      r_valid_r <= r_valid_nxt;
      r_data_r <= r_data_nxt;
      r_resp_r <= r_resp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  ////////////////////////////////////////////////////////////////////////////
  sequence trig_wb_s;
    wr_lo && wq_r.addr == `CMFC_OFF_WB && wq_r.data[0] && !sw_busy && !wb_r && !wbinv_r;
  endsequence
  sequence trig_inv_s;
    wr_lo && wq_r.addr == `CMFC_OFF_WBINV && wq_r.data[0] && !sw_busy && !wb_r && !wbinv_r;
  endsequence

  wb_launch_a: assert property (@(posedge MCLK) disable iff (!RSTN) // R1
    trig_wb_s |=> wb_r && LINE_REQ && !LINE_INVAL && LINE_IDX == 16'h0000)
    else $error("writeback trigger did not start a sweep");
  inv_launch_a: assert property (@(posedge MCLK) disable iff (!RSTN) // R2
    trig_inv_s |=> wbinv_r && LINE_REQ && LINE_INVAL)
    else $error("invalidate trigger did not start a sweep");
  hi_zero_a: assert property (@(posedge MCLK) disable iff (!RSTN) // R3
    S_AXI_RVALID && $rose(S_AXI_RVALID) && $past(S_AXI_ARADDR) != `CMFC_OFF_PCS
      && $past(S_AXI_ARADDR) != `CMFC_OFF_LINES |-> S_AXI_RDATA[31:3] == 29'h0)
    else $error("reserved read bits not zero");
  range_block_a: assert property (@(posedge MCLK) disable iff (!RSTN) // R4
    REQ_EXT && REQ_ADDR[31:24] == 8'hff && NRANGE == 256 |-> REQ_CACHEABLE == ce_r[255])
    else $error("range block select wrong");
  ce_write_a: assert property (@(posedge MCLK) disable iff (!RSTN) // R5
    wr_lo && wq_r.addr[11:10] == 2'h1 |=> ce_r[$past(wr_ridx)] == $past(wq_r.data[0]))
    else $error("range enable not stored");
  dcc_legal_a: assert property (@(posedge MCLK) disable iff (!RSTN) // R7
    DATA_CACHE_CONTROL == 3'h0 || DATA_CACHE_CONTROL == 3'h2)
    else $error("illegal data cache code");
  pcc_legal_a: assert property (@(posedge MCLK) disable iff (!RSTN) // R9
    PROGRAM_CACHE_CONTROL == 3'h0 || PROGRAM_CACHE_CONTROL == 3'h2)
    else $error("illegal program cache code");
  no_alloc_a: assert property (@(posedge MCLK) disable iff (!RSTN) // R11
    SECOND_LEVEL_SPLIT == 3'h0 |-> !REQ_L2_ALLOC)
    else $error("all-SRAM mode kept a copy");
  safe_read_a: assert property (@(posedge MCLK) disable iff (!RSTN) // R13
    !REQ_EXT && !REQ_WRITE && REQ_ADDR == 32'h0010_0fff |-> REQ_L2_READ_SAFE)
    else $error("window read not safe");
  indep_split_a: assert property (@(posedge MCLK) disable iff (!RSTN) // R15
    $changed(SECOND_LEVEL_SPLIT) && $stable(REQ_ADDR) && $stable(REQ_EXT) && $stable(ce_r)
      |-> $stable(REQ_CACHEABLE))
    else $error("cacheability follows split");
  inv_hold_a: assert property (@(posedge MCLK) disable iff (!RSTN) // R20
    wbinv_r && !sw_finish |=> wbinv_r)
    else $error("invalidate bit cleared early");
  wb_clear_a: assert property (@(posedge MCLK) disable iff (!RSTN) // R21
    sw_finish |=> !wb_r && !wbinv_r)
    else $error("trigger bit not cleared on finish");
endmodule : cmfc_top

//--- verif/cmfc_line_model.sv
// Purpose: Line engine model that answers each sweep line with a one-cycle done pulse.
// Assumes: The line request is a level held until the last line is answered.
// Notes: Delay input picks a prompt (0) or slow answer; counts the lines served.
module cmfc_line_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic line_req,
  input wire logic line_inval,
  input wire logic [3:0] dly,
  output logic line_done,
  output int n_done,
  output int n_inv
);
  logic [3:0] cnt_r; // Cycles waited on the current line
  ////////////////////////////////////////////////////////////////////////////////
  // One pulse per line; no answer is given in the pulse cycle itself, so no line is answered twice
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
      line_done <= 1'b0;
      n_done <= 0;
      n_inv <= 0;
    end else if (line_req && !line_done && cnt_r >= dly) begin
      line_done <= 1'b1;
      cnt_r <= 4'h0;
      n_done <= n_done + 1;
      n_inv <= n_inv + int'(line_inval);
    end else begin
      line_done <= 1'b0;
      cnt_r <= (line_req && !line_done) ? cnt_r + 4'h1 : 4'h0;
    end
  end
endmodule : cmfc_line_model

//--- verif/cmfc_top_tb.sv
// Purpose: Self-checking bench for the cache mode and flush control.
// Assumes: AXI4-Lite master tasks, line engine model, sweep length cut to 4 lines.
// Notes: Random values come from a fixed seed; expectations are worked out here.
`include "cmfc_defs.svh"
module cmfc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LN = 4; // Short sweep keeps the run brief
  logic mclk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic ext = 1'b0, wr = 1'b0, awr, wrdy, bv, arr, rv, cach, alloc, rsafe, lreq, linv, ldone;
  logic [11:0] awa = 12'h0, ara = 12'h0;
  logic [31:0] wd = 32'h0, raddr = 32'h0, rdata, rd, v;
  logic [3:0] ws = 4'h0, dly = 4'h0;
  logic [1:0] brs, rrs, rr;
  logic [2:0] split, dcc, program_cache_control, sp, ed, ep;
  logic [15:0] lidx;
  logic pe, pw; // Random probe kind: external, write
  logic ce [256]; // Expected range enables
  int n_fail = 0, n_checks = 0, seed, n, d0, i0, nd, ni;
  ////////////////////////////////////////////////////////////////////////////////
  always #2 mclk = ~mclk;
  cmfc_top #(.NRANGE(256), .LINES(LN)) dut_u (.MCLK(mclk), .RSTN(rstn), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrdy), .S_AXI_BRESP(brs), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rrs), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rry), .REQ_ADDR(raddr), .REQ_EXT(ext), .REQ_WRITE(wr), .REQ_CACHEABLE(cach),
    .REQ_L2_ALLOC(alloc), .REQ_L2_READ_SAFE(rsafe), .SECOND_LEVEL_SPLIT(split), .DATA_CACHE_CONTROL(dcc),
    .PROGRAM_CACHE_CONTROL(program_cache_control), .LINE_REQ(lreq), .LINE_INVAL(linv), .LINE_IDX(lidx), .LINE_DONE(ldone));
  cmfc_line_model line_u (.clk(mclk), .rst_n(rstn), .line_req(lreq), .line_inval(linv), .dly(dly),
    .line_done(ldone), .n_done(nd), .n_inv(ni));
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  // Every wait passes through here so a hang ends the run
  task automatic guard(inout int k);
    k++;
    if (k > 400) begin
      n_fail++;
      $display("MISMATCH t=%0t wait limit used up", $time);
      results();
    end
  endtask : guard
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_data
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t response got %h exp %h", $time, got, exp);
    end
  endtask : chk_resp
  ////////////////////////////////////////////////////////////////////////////////
  // Write: both channels offered together, each dropped once taken; ready checked before the edge
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    logic ah, wh, hit;
    k = 0;
    awa <= a;
    wd <= d;
    ws <= 4'hf;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(negedge mclk);
      ah = awv && awr;
      wh = wv && wrdy;
      hit = (ah || !awv) && (wh || !wv);
      @(posedge mclk);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
      guard(k);
    end while (!hit);
    do begin
      @(negedge mclk);
      hit = bv;
      rr = brs;
      @(posedge mclk);
      guard(k);
    end while (!hit);
    // Response ready stays up between writes, so no second assignment in one step
    chk_resp(rr, er);
  endtask : axw
  // Read: address held until taken, data sampled mid-cycle once read valid is seen
  task automatic axr(input logic [11:0] a);
    int k;
    logic hit;
    k = 0;
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(negedge mclk);
      hit = arr;
      @(posedge mclk);
      guard(k);
    end while (!hit);
    arv <= 1'b0;
    do begin
      @(negedge mclk);
      hit = rv;
      rd = rdata;
      rr = rrs;
      @(posedge mclk);
      guard(k);
    end while (!hit);
  endtask : axr
  task automatic reg_rd(input logic [11:0] a, input logic [31:0] ed_v, input logic [1:0] er);
    axr(a);
    chk_data(rd, ed_v, "read data");
    chk_resp(rr, er);
  endtask : reg_rd
  // Split change in the safe order: global flush, write, read back, then 8 idle cycles
  task automatic cfg_switch(input logic [2:0] nw);
    int k;
    k = 0;
    axw(`CMFC_OFF_WBINV, 32'h1, `CMFC_RESP_OKAY);
    do begin
      axr(`CMFC_OFF_WBINV);
      guard(k);
    end while (rd[0] !== 1'b0);
    axw(`CMFC_OFF_CFG, {29'h0, nw}, `CMFC_RESP_OKAY);
    reg_rd(`CMFC_OFF_CFG, {29'h0, nw}, `CMFC_RESP_OKAY);
    repeat (8) @(posedge mclk);
  endtask : cfg_switch
  // Cache-side probe; outputs judged mid-cycle once settled
  task automatic probe(input logic [31:0] a, input logic e, input logic w);
    raddr <= a;
    ext <= e;
    wr <= w;
    @(negedge mclk);
    chk_data({31'h0, cach}, {31'h0, e & ce[a[31:24]]}, "cacheable");
    chk_data({31'h0, alloc}, {31'h0, e & ce[a[31:24]] & (sp != 3'h0)}, "allocate");
    chk_data({31'h0, rsafe}, {31'h0, !e && !w && a <= `CMFC_L2_READ_TOP}, "read safe");
    @(posedge mclk);
  endtask : probe
  // Reserved codes leave the field as it was
  function automatic logic [2:0] keep(input logic [2:0] old, input logic [2:0] nw);
    return (nw == `CMFC_MODE_CACHE0 || nw == `CMFC_MODE_CACHE1) ? nw : old;
  endfunction : keep
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 99;
    sp = 3'h0;
    ed = 3'h0;
    ep = 3'h0;
    foreach (ce[i]) ce[i] = 1'b0;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    reg_rd(`CMFC_OFF_WB, 32'h0, `CMFC_RESP_OKAY);
    reg_rd(`CMFC_OFF_WBINV, 32'h0, `CMFC_RESP_OKAY);
    reg_rd(`CMFC_OFF_CFG, 32'h0, `CMFC_RESP_OKAY);
    reg_rd(12'h7fc, 32'h0, `CMFC_RESP_OKAY);
    chk_data({29'h0, split}, 32'h0, "split port");
    // Only the two legal codes are written; data and program codes crossed twice
    for (int c = 0; c < 8; c++) begin
      ed = keep(ed, c[0] ? 3'h2 : 3'h0);
      ep = keep(ep, c[1] ? 3'h2 : 3'h0);
      axw(`CMFC_OFF_PCS, {24'h0, ep, ed, 2'h0}, `CMFC_RESP_OKAY);
      axr(`CMFC_OFF_PCS);
      chk_data({26'h0, rd[7:2]}, {26'h0, ep, ed}, "mode fields");
      chk_data({26'h0, program_cache_control, dcc}, {26'h0, ep, ed}, "mode ports");
    end
    // Random range enables and split codes, each followed by probes
    for (int i = 0; i < 24; i++) begin
      n = $random(seed) & 255;
      v = $random(seed);
      axw(12'(`CMFC_OFF_RANGE + 4 * n), {31'h0, v[0]}, `CMFC_RESP_OKAY);
      ce[n] = v[0];
      reg_rd(12'(`CMFC_OFF_RANGE + 4 * n), {31'h0, v[0]}, `CMFC_RESP_OKAY);
      sp = 3'($random(seed));
      cfg_switch(sp);
      chk_data({29'h0, split}, {29'h0, sp}, "split port");
      probe({n[7:0], 24'($random(seed))}, 1'b1, 1'b0);
      pe = 1'($random(seed));
      pw = 1'($random(seed));
      v = $random(seed);
      // Internal writes go to the bottom word, which never turns into cache
      probe((pw && !pe) ? 32'h0 : v, pe, pw);
    end
    probe(`CMFC_L2_READ_TOP, 1'b0, 1'b0);
    probe(`CMFC_L2_READ_TOP + 32'h1, 1'b0, 1'b0);
    // Top block of the address space against the last range register
    axw(12'h7fc, 32'h1, `CMFC_RESP_OKAY);
    ce[255] = 1'b1;
    probe(32'hff00_0000, 1'b1, 1'b0);
    // Sweeps: slow writeback, slow invalidate, prompt writeback
    for (int k = 0; k < 3; k++) begin
      dly <= (k == 2) ? 4'h0 : 4'h5;
      d0 = nd;
      i0 = ni;
      axw(k[0] ? `CMFC_OFF_WBINV : `CMFC_OFF_WB, 32'h1, `CMFC_RESP_OKAY);
      if (k < 2) reg_rd(k[0] ? `CMFC_OFF_WBINV : `CMFC_OFF_WB, 32'h1, `CMFC_RESP_OKAY);
      n = 0;
      do begin
        axr(k[0] ? `CMFC_OFF_WBINV : `CMFC_OFF_WB);
        guard(n);
      end while (rd[0] !== 1'b0);
      chk_data(nd - d0, LN, "lines swept");
      chk_data(ni - i0, k[0] ? LN : 0, "lines invalidated");
      chk_data({16'h0, lidx}, LN - 1, "last line");
    end
    // A write of 0 is normal operation: no sweep starts
    d0 = nd;
    axw(`CMFC_OFF_WB, 32'h0, `CMFC_RESP_OKAY);
    reg_rd(`CMFC_OFF_WB, 32'h0, `CMFC_RESP_OKAY);
    chk_data(nd - d0, 0, "no sweep");
    // Unmapped place
    axw(12'h100, $random(seed), `CMFC_RESP_SLVERR);
    reg_rd(12'h100, 32'h0, `CMFC_RESP_SLVERR);
    results();
  end
endmodule : cmfc_top_tb
